/* hw/slfr_link_fault.sv */
// slfr_link_fault: receive side of the single-wire link with fault detection and reporting.
// assumes an APB3 master on the register side and a synchronous serial input.
module slfr_link_fault #(
   parameter int FAULT_TIMER_CYCLES = slfr_pkg::FAULT_TIMER_CYC
) (
   input  wire logic                    i_ref_clk,             // clock, 25 MHz
   input  wire logic                    i_reset,               // sync reset, active high
   input  wire logic                    i_psel,                // apb select
   input  wire logic                    i_penable,             // apb access phase
   input  wire logic                    i_pwrite,              // apb write
   input  wire logic [7:0]              i_paddr,               // apb byte address
   input  wire logic [31:0]             i_pwdata,              // apb write data
   output logic      [31:0]             o_prdata,              // apb read data
   output logic                         o_pready,              // apb ready
   output logic                         o_pslverr,             // apb error, unmapped address
   input  wire logic                    i_din,                 // serial symbol input
   input  wire logic                    i_fault_level_select,  // 1 high fault code, 0 low; a drive fault always gives the low code
   input  wire logic                    i_loop_overload,       // output stage cannot hold current
   output logic                         o_ack_out_n,           // acknowledge, active low
   output logic                         o_latch_feedback_out,  // acknowledge drive on return line
   output logic                         o_fault_flag_n,        // fault flag, active low
   output logic [slfr_pkg::DATA_W-1:0]  o_current_code,        // code driving the loop current
   output logic                         o_irq                  // interrupt, level
);
   import slfr_pkg::*;

   slfr_sym_type           sym;
   slfr_fault_type         act;
   slfr_fault_type         rpt;
   logic [3:0]             fault_mask_config_q;
   logic [DATA_W-1:0]      output_code_q;
   logic [DATA_W-1:0]      fault_high_q;
   logic [DATA_W-1:0]      fault_low_q;
   logic [PERIOD_W-1:0]    sym_period_q;
   logic [IRQ_W-1:0]       irq_status_q;
   logic [IRQ_W-1:0]       irq_mask_q;
   logic [IRQ_W-1:0]       irq_ev;
   logic [FRAME_SYMS-1:0]  bits_q;
   logic [4:0]             nsym_q;
   logic                   parity_q;
   logic                   frame_q;
   logic                   drive_q;
   logic                   idle_exp;
   logic                   idle_exp_q;
   logic                   drive_exp;
   logic                   data_sym;
   logic                   valid_sym;
   logic                   frame_end;
   logic                   good_frame;
   logic                   bad_parity;
   logic                   bad_frame;
   logic                   drive_set;
   logic [PERIOD_W-1:0]    ack_cnt_q;
   logic                   ack_n_q;
   logic                   flag_n_q;
   logic [DATA_W-1:0]      code_q;
   logic                   wr;
   logic                   setup;
   logic [31:0]            rd_mux;
   logic                   rd_hit;

   slfr_symbol_decoder #(
      .PERIOD_W (PERIOD_W)
   ) u_dec (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_din     (i_din),
      .i_period  (sym_period_q),
      .o_sym     (sym)
   );

   // idle watchdog restarts on every valid symbol
   slfr_interval_timer #(
      .CYCLES (FAULT_TIMER_CYCLES)
   ) u_idle_tmr (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_restart (valid_sym),
      .o_expired (idle_exp)
   );

   // retry timer for the drive fault
   slfr_interval_timer #(
      .CYCLES (FAULT_TIMER_CYCLES)
   ) u_drive_tmr (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_restart (drive_set),
      .o_expired (drive_exp)
   );

   assign data_sym   = sym.valid && (sym.kind == SYM_ZERO || sym.kind == SYM_ONE);
   assign valid_sym  = data_sym || (sym.valid && sym.kind == SYM_CHECK);
   assign frame_end  = sym.valid && !data_sym && (nsym_q != 5'h00);
   assign good_frame = frame_end && sym.kind != SYM_INVALID && nsym_q == 5'(FRAME_SYMS) && !(^bits_q);
   assign bad_parity = frame_end && sym.kind != SYM_INVALID && nsym_q == 5'(FRAME_SYMS) && (^bits_q);
   assign bad_frame  = (sym.valid && sym.kind == SYM_INVALID)
                     || (frame_end && nsym_q != 5'(FRAME_SYMS));
   assign drive_set  = i_loop_overload && !drive_q;

   // frame assembly: data symbols shift in msb first, last one is even parity
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         bits_q <= '0;
         nsym_q <= 5'h00;
      end else if (data_sym) begin
         bits_q <= {bits_q[FRAME_SYMS-2:0], sym.kind == SYM_ONE};
         if (nsym_q != 5'h1F) begin
            nsym_q <= nsym_q + 5'h01;
         end
      end else if (sym.valid) begin
         nsym_q <= 5'h00;
      end
   end

   // frame faults persist until the next good frame
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         parity_q <= 1'b0;
         frame_q  <= 1'b0;
      end else begin
         if (bad_parity) begin
            parity_q <= 1'b1;
         end else if (good_frame) begin
            parity_q <= 1'b0;
         end
         if (bad_frame) begin
            frame_q <= 1'b1;
         end else if (good_frame) begin
            frame_q <= 1'b0;
         end
      end
   end

   // drive fault clears itself after the interval; a persisting overload re-raises it
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         drive_q <= 1'b0;
      end else if (drive_set) begin
         drive_q <= 1'b1;
      end else if (drive_q && drive_exp) begin
         drive_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         idle_exp_q <= 1'b0;
      end else begin
         idle_exp_q <= idle_exp;
      end
   end

   assign act = '{frame: frame_q, parity: parity_q, idle: idle_exp, drive: drive_q};
   assign rpt = act & slfr_fault_type'(fault_mask_config_q);

   // reported flag and loop current code, one cycle behind the fault state
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         flag_n_q <= 1'b1;
         code_q   <= OUTPUT_CODE_RST;
      end else begin
         flag_n_q <= !(|rpt);
         if (rpt.drive) begin
            code_q <= fault_low_q;
         end else if (rpt.idle || rpt.parity || rpt.frame) begin
            code_q <= i_fault_level_select ? fault_high_q : fault_low_q;
         end else begin
            code_q <= output_code_q;
         end
      end
   end

   // acknowledge: one symbol period after each good frame, on both outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ack_cnt_q <= '0;
         ack_n_q   <= 1'b1;
      end else if (good_frame) begin
         ack_cnt_q <= sym_period_q;
         ack_n_q   <= 1'b0;
      end else if (ack_cnt_q != '0) begin
         ack_cnt_q <= ack_cnt_q - PERIOD_W'(1);
         if (ack_cnt_q == PERIOD_W'(1)) begin
            ack_n_q <= 1'b1;
         end
      end
   end

   assign o_ack_out_n          = ack_n_q;
   assign o_latch_feedback_out = ~ack_n_q;
   assign o_fault_flag_n       = flag_n_q;
   assign o_current_code       = code_q;

   // apb slave: zero wait states, read data captured in the setup cycle
   assign setup    = i_psel && !i_penable;
   assign wr       = i_psel && i_penable && i_pwrite;
   assign o_pready = i_psel && i_penable;

   always_comb begin
      rd_hit = 1'b1;
      unique case (i_paddr)
         OFS_FAULT_MASK:  rd_mux = {28'h0000000, fault_mask_config_q};
         OFS_STATUS:      rd_mux = {26'h0, ~ack_n_q, i_fault_level_select, act};
         OFS_OUTPUT_CODE: rd_mux = {16'h0000, output_code_q};
         OFS_FAULT_HIGH:  rd_mux = {16'h0000, fault_high_q};
         OFS_FAULT_LOW:   rd_mux = {16'h0000, fault_low_q};
         OFS_SYM_PERIOD:  rd_mux = {16'h0000, sym_period_q};
         OFS_IRQ_STATUS:  rd_mux = {27'h0, irq_status_q};
         OFS_IRQ_MASK:    rd_mux = {27'h0, irq_mask_q};
         default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_prdata  <= i_pwrite ? 32'h00000000 : rd_mux;
         o_pslverr <= !rd_hit;
      end
   end

   // software registers; a good frame overrides a same-cycle code write
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         fault_mask_config_q <= FAULT_MASK_RST;
         output_code_q       <= OUTPUT_CODE_RST;
         fault_high_q        <= FAULT_HIGH_RST;
         fault_low_q         <= FAULT_LOW_RST;
         sym_period_q        <= SYM_PERIOD_RST;
         irq_mask_q          <= IRQ_MASK_RST;
      end else begin
         if (wr && i_paddr == OFS_FAULT_MASK) begin
            fault_mask_config_q <= i_pwdata[3:0];
         end
         if (good_frame) begin
            output_code_q <= bits_q[FRAME_SYMS-1:1];
         end else if (wr && i_paddr == OFS_OUTPUT_CODE) begin
            output_code_q <= i_pwdata[DATA_W-1:0];
         end
         if (wr && i_paddr == OFS_FAULT_HIGH) begin
            fault_high_q <= i_pwdata[DATA_W-1:0];
         end
         if (wr && i_paddr == OFS_FAULT_LOW) begin
            fault_low_q <= i_pwdata[DATA_W-1:0];
         end
         if (wr && i_paddr == OFS_SYM_PERIOD) begin
            sym_period_q <= i_pwdata[PERIOD_W-1:0];
         end
         if (wr && i_paddr == OFS_IRQ_MASK) begin
            irq_mask_q <= i_pwdata[IRQ_W-1:0];
         end
      end
   end

   // sticky events; a new event in the clearing cycle survives
   assign irq_ev[IRQ_DRIVE]  = drive_set;
   assign irq_ev[IRQ_IDLE]   = idle_exp && !idle_exp_q;
   assign irq_ev[IRQ_PARITY] = bad_parity;
   assign irq_ev[IRQ_FRAME]  = bad_frame;
   assign irq_ev[IRQ_GOOD]   = good_frame;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         irq_status_q <= '0;
      end else if (wr && i_paddr == OFS_IRQ_STATUS) begin
         irq_status_q <= (irq_status_q & ~i_pwdata[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_status_q <= irq_status_q | irq_ev;
      end
   end

   assign o_irq = |(irq_status_q & irq_mask_q);

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   a_ack_pair_same:   assert property (o_ack_out_n == !o_latch_feedback_out)
      else $error("ack outputs disagree");
   a_ack_after_frame: assert property (good_frame && sym_period_q > 16'h0001
                                       |=> !o_ack_out_n [*2])
      else $error("no ack after good frame");
   a_flag_enabled:    assert property (|rpt |=> !o_fault_flag_n)
      else $error("fault flag not low");
   a_mask_suppress:   assert property (fault_mask_config_q == 4'h0 |=> o_fault_flag_n)
      else $error("masked fault reported");
   a_drive_low_code:  assert property (rpt.drive |=> o_current_code == $past(fault_low_q))
      else $error("drive fault code wrong");
   a_level_high_code: assert property (!rpt.drive && rpt.parity && i_fault_level_select
                                       |=> o_current_code == $past(fault_high_q))
      else $error("high fault code wrong");
   a_restore_code:    assert property (rpt == '0 |=> o_fault_flag_n
                                       && o_current_code == $past(output_code_q))
      else $error("valid code not restored");
   a_drive_clears:    assert property ($fell(drive_q) |-> $past(drive_exp))
      else $error("drive fault cleared early");
   a_idle_restart:    assert property (valid_sym |=> !act.idle [*2])
      else $error("idle fault despite symbol");
   a_parity_sets:     assert property (bad_parity |=> parity_q && irq_status_q[IRQ_PARITY])
      else $error("parity fault missed");
   a_frame_sets:      assert property (bad_frame |=> frame_q)
      else $error("frame fault missed");

   c_good_frame:  cover property (good_frame ##1 !o_ack_out_n);
   c_parity:      cover property (bad_parity);
   c_drive_retry: cover property ($fell(drive_q));
   c_idle:        cover property ($rose(act.idle));

endmodule : slfr_link_fault

/* shared/slfr_pkg.sv */
// slfr_pkg: constants, register map and carrier types for the link fault reporting block.
// assumes a single 25 MHz clock domain; all offsets are APB byte addresses.
package slfr_pkg;

   localparam int          CLK_HZ           = 25_000_000;
   localparam int          DATA_W           = 16;
   localparam int          FRAME_SYMS       = 17;
   localparam int          PERIOD_W         = 16;
   localparam int          FAULT_TIMER_MS   = 100;
   localparam int          FAULT_TIMER_CYC  = FAULT_TIMER_MS * (CLK_HZ / 1000);

   localparam logic [7:0]  OFS_FAULT_MASK   = 8'h00;
   localparam logic [7:0]  OFS_STATUS       = 8'h04;
   localparam logic [7:0]  OFS_OUTPUT_CODE  = 8'h08;
   localparam logic [7:0]  OFS_FAULT_HIGH   = 8'h0C;
   localparam logic [7:0]  OFS_FAULT_LOW    = 8'h10;
   localparam logic [7:0]  OFS_SYM_PERIOD   = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK     = 8'h1C;

   localparam logic [3:0]  FAULT_MASK_RST   = 4'hF;
   localparam logic [15:0] OUTPUT_CODE_RST  = 16'h0000;
   localparam logic [15:0] FAULT_HIGH_RST   = 16'hE000;
   localparam logic [15:0] FAULT_LOW_RST    = 16'h1000;
   localparam logic [15:0] SYM_PERIOD_RST   = 16'h0064;
   localparam logic [4:0]  IRQ_MASK_RST     = 5'h00;

   // irq status bit positions
   localparam int          IRQ_DRIVE        = 0;
   localparam int          IRQ_IDLE         = 1;
   localparam int          IRQ_PARITY       = 2;
   localparam int          IRQ_FRAME        = 3;
   localparam int          IRQ_GOOD         = 4;
   localparam int          IRQ_W            = 5;

   typedef enum logic [4:0] {
      SYM_ZERO    = 5'h01,
      SYM_ONE     = 5'h02,
      SYM_CHECK   = 5'h04,
      SYM_IDLE    = 5'h08,
      SYM_INVALID = 5'h10
   } slfr_sym_kind_type;

   typedef struct packed {
      logic              valid;
      slfr_sym_kind_type kind;
   } slfr_sym_type;

   // bit 0 drive, 1 idle, 2 parity, 3 frame
   typedef struct packed {
      logic frame;
      logic parity;
      logic idle;
      logic drive;
   } slfr_fault_type;

endpackage : slfr_pkg

/* hw/slfr_interval_timer.sv */
// slfr_interval_timer: counts a fixed interval after a restart and then holds expired.
// assumes restart is a one-cycle request in the i_ref_clk domain.
module slfr_interval_timer #(
   parameter int CYCLES = slfr_pkg::FAULT_TIMER_CYC
) (
   input  wire logic i_ref_clk,   // clock
   input  wire logic i_reset,     // sync reset, active high
   input  wire logic i_restart,   // restart the interval
   output logic      o_expired    // interval elapsed since last restart
);
   import slfr_pkg::*;

   localparam int          CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(CYCLES);

   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset || i_restart) begin
         cnt_q <= '0;
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   assign o_expired = (cnt_q == LIMIT);

endmodule : slfr_interval_timer

/* hw/slfr_symbol_decoder.sv */
// slfr_symbol_decoder: classifies each high phase on the serial input by its duty within the period.
// assumes i_din is already synchronous to i_ref_clk and symbols start on a rising edge.
module slfr_symbol_decoder #(
   parameter int PERIOD_W = slfr_pkg::PERIOD_W
) (
   input  wire logic                  i_ref_clk,  // clock
   input  wire logic                  i_reset,    // sync reset, active high
   input  wire logic                  i_din,      // serial input
   input  wire logic [PERIOD_W-1:0]   i_period,   // symbol period in cycles
   output slfr_pkg::slfr_sym_type     o_sym       // decoded symbol, valid one cycle
);
   import slfr_pkg::*;

   localparam int CW = PERIOD_W + 3;

   typedef enum logic [1:0] {
      S_LOW  = 2'b01,
      S_HIGH = 2'b10
   } slfr_dec_state_type;

   slfr_dec_state_type state_q;
   logic [CW-1:0]      cnt_q;
   logic               din_q;
   logic [CW-1:0]      per;
   logic [CW-1:0]      h8;
   logic               rise;
   logic               fall;
   slfr_sym_kind_type  duty_kind;

   assign per  = CW'(i_period);
   assign h8   = {cnt_q[CW-4:0], 3'b000};
   assign rise = i_din & ~din_q;
   assign fall = ~i_din & din_q;

   // nearest of 25, 50 and 75 percent; anything near full period is invalid
   always_comb begin
      if (h8 < CW'(per * CW'(3))) begin
         duty_kind = SYM_ZERO;
      end else if (h8 < CW'(per * CW'(5))) begin
         duty_kind = SYM_CHECK;
      end else if (h8 < CW'(per * CW'(7))) begin
         duty_kind = SYM_ONE;
      end else begin
         duty_kind = SYM_INVALID;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_q <= S_LOW;
         cnt_q   <= '0;
         din_q   <= 1'b0;
         o_sym   <= '{valid: 1'b0, kind: SYM_IDLE};
      end else begin
         din_q       <= i_din;
         o_sym.valid <= 1'b0;
         unique case (state_q)
            S_LOW: begin
               if (rise) begin
                  state_q <= S_HIGH;
                  cnt_q   <= '0;
               end else if (cnt_q >= per + (per >> 1)) begin
                  // no rise half a period late: an all-low symbol, keep phase
                  o_sym   <= '{valid: 1'b1, kind: SYM_IDLE};
                  cnt_q   <= per >> 1;
               end else begin
                  cnt_q   <= cnt_q + CW'(1);
               end
            end
            S_HIGH: begin
               if (fall) begin
                  state_q <= S_LOW;
                  cnt_q   <= cnt_q + CW'(1);
                  if (cnt_q < per) begin
                     o_sym <= '{valid: 1'b1, kind: duty_kind};
                  end
               end else if (cnt_q == per) begin
                  // stuck high for a whole period; reported once
                  o_sym <= '{valid: 1'b1, kind: SYM_INVALID};
                  cnt_q <= cnt_q + CW'(1);
               end else if (cnt_q < per) begin
                  cnt_q <= cnt_q + CW'(1);
               end
            end
         endcase
      end
   end

endmodule : slfr_symbol_decoder

/* dv/slfr_master_model.sv */
// slfr_master_model: link master sending duty-coded symbols on the serial input.
// assumes one caller at a time; the line rests low between frames.
module slfr_master_model (
   input  wire logic        i_ref_clk,  // clock
   input  wire logic [15:0] i_period,   // symbol period, cycles
   input  wire logic        i_ack_n,    // acknowledge from the device, active low
   output logic             o_din,      // serial line to the device
   output logic             o_tx_en_n,  // direction control, low while sending
   output logic             o_ack_seen  // acknowledge caught while listening
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_din      = 1'b0;
      o_tx_en_n  = 1'b1;
      o_ack_seen = 1'b0;
   end
   // an acknowledge only counts while the drive is released
   always @(posedge i_ref_clk) begin
      if (!o_tx_en_n)
         o_ack_seen <= 1'b0;
      else if (i_ack_n === 1'b0)
         o_ack_seen <= 1'b1;
   end
   // high for h cycles, then low to the end of the period
   task automatic send_sym(input int h);
      o_tx_en_n <= 1'b0;
      repeat (h) @(posedge i_ref_clk) o_din <= 1'b1;
      repeat (int'(i_period) - h) @(posedge i_ref_clk) o_din <= 1'b0;
   endtask : send_sym
   // n data symbols msb first, even parity (flip breaks it), check symbol
   task automatic send_frame(input logic [15:0] d, input logic flip, input int n);
      int p;
      p = int'(i_period);
      for (int i = 15; i > 15 - n; i--)
         send_sym(d[i] ? p * 3 / 4 : p / 4);
      send_sym((^d ^ flip) ? p * 3 / 4 : p / 4);
      send_sym(p / 2);
      // release inside the acknowledge span and listen
      o_tx_en_n <= 1'b1;
   endtask : send_frame
endmodule : slfr_master_model

/* dv/test_single_wire_interface_link_fault_reporting.sv */
// test_single_wire_interface_link_fault_reporting: apb and link tests of the fault reporting block.
// assumes zero-wait apb and the master model on the serial input.
module test_single_wire_interface_link_fault_reporting;
   import slfr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          TMR_CYC = 64;
   localparam logic [15:0] P  = 16'h0008;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, lvl = 1, ovl = 0, perr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, din, ack_n, fb, flag_n, irq, tx_en_n, ack_seen;
   logic [15:0] code;
   int          failures = 0, num_checks = 0, ack_run = 0, ack_len = 0;
   always #20 clk = ~clk;
   slfr_link_fault #(.FAULT_TIMER_CYCLES(TMR_CYC)) DUT (.i_ref_clk(clk), .i_reset(rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_din(din), .i_fault_level_select(lvl),
      .i_loop_overload(ovl), .o_ack_out_n(ack_n), .o_latch_feedback_out(fb),
      .o_fault_flag_n(flag_n), .o_current_code(code), .o_irq(irq));
   slfr_master_model M (.i_ref_clk(clk), .i_period(P), .i_ack_n(ack_n), .o_din(din),
      .o_tx_en_n(tx_en_n), .o_ack_seen(ack_seen));
   // counts only cycles where both acknowledge outputs are asserted
   always @(posedge clk) begin
      if (ack_n === 1'b0 && fb === 1'b1)
         ack_run <= ack_run + 1;
      else if (ack_run != 0) begin
         ack_len <= ack_run;
         ack_run <= 0;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) begin
         failures++;
         test_done();
      end
      rd   = prdata;
      perr = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   // settle covers ack length plus fault and code lag
   task automatic frame(input logic [15:0] d, input logic flip, input int n);
      M.send_frame(d, flip, n);
      repeat (12) @(posedge clk);
   endtask : frame
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdc(OFS_FAULT_MASK, 32'h0000000F);
      rdc(OFS_FAULT_HIGH, 32'h0000E000);
      rdc(OFS_FAULT_LOW, 32'h00001000);
      rdc(OFS_SYM_PERIOD, 32'h00000064);
      rdc(8'h20, 32'h00000000);
      chk(perr, 32'h1);
      apb(1'b1, OFS_SYM_PERIOD, 32'(P));
      apb(1'b1, OFS_FAULT_MASK, 32'hD);
      apb(1'b1, OFS_IRQ_MASK, 32'h1F);
      $display("registers done");
      frame(16'hA5C3, 1'b0, 16);
      chk(ack_len, 32'(P));
      chk(ack_seen, 32'h1);
      chk(code, 32'hA5C3);
      chk(flag_n, 32'h1);
      chk(irq, 32'h1);
      apb(1'b1, OFS_IRQ_STATUS, 32'h1F);
      @(negedge clk);
      chk(irq, 32'h0);
      $display("good frame done");
      frame(16'h1234, 1'b1, 16);
      chk(flag_n, 32'h0);
      chk(ack_seen, 32'h0);
      chk(code, 32'hE000);
      lvl <= 1'b0;
      repeat (2) @(negedge clk);
      chk(code, 32'h1000);
      frame(16'h1234, 1'b0, 16);
      chk(flag_n, 32'h1);
      chk(code, 32'h1234);
      $display("parity done");
      frame(16'h00FF, 1'b0, 8);
      chk(flag_n, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[3], 32'h1);
      apb(1'b1, OFS_FAULT_MASK, 32'h5);
      repeat (2) @(negedge clk);
      chk(flag_n, 32'h1);
      chk(code, 32'h1234);
      apb(1'b1, OFS_FAULT_MASK, 32'h0);
      repeat (2) @(negedge clk);
      chk(flag_n, 32'h1);
      apb(1'b1, OFS_FAULT_MASK, 32'hD);
      frame(16'h1234, 1'b0, 16);
      chk(flag_n, 32'h1);
      M.send_sym(int'(P));
      M.send_sym(0);
      repeat (12) @(posedge clk);
      chk(flag_n, 32'h0);
      frame(16'h1234, 1'b0, 16);
      chk(flag_n, 32'h1);
      $display("frame done");
      apb(1'b1, OFS_IRQ_STATUS, 32'h1F);
      lvl <= 1'b1;
      ovl <= 1'b1;
      repeat (3) @(posedge clk);
      ovl <= 1'b0;
      @(negedge clk);
      chk(flag_n, 32'h0);
      chk(code, 32'h1000);
      chk(irq, 32'h1);
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      @(negedge clk);
      chk(irq, 32'h0);
      repeat (TMR_CYC + 8) @(posedge clk);
      chk(flag_n, 32'h1);
      chk(code, 32'h1234);
      $display("overload done");
      apb(1'b1, OFS_FAULT_MASK, 32'hF);
      repeat (2) @(negedge clk);
      chk(flag_n, 32'h0);
      chk(code, 32'hE000);
      $display("idle done");
      test_done();
   end
endmodule : test_single_wire_interface_link_fault_reporting
